// ---- design/frsr_follower_ref.sv ----
// Purpose: Follower speed reference, ramp and drive loop with APB registers
// Assumes: Single clock, sensor inputs synchronous, APB slave, no waits
// Notes: One shared serial divider; a gate must outlast a full computation
`timescale 1ns/1ps
module frsr_follower_ref #(
  parameter int GATE_CYCLES = frsr_pkg::GATE_CYCLES_DEF
) (
  input wire logic i_clk, // System clock
  input wire logic i_rst_b, // Async reset, active low
  input wire logic i_psel, // APB select
  input wire logic i_penable, // APB enable
  input wire logic i_pwrite, // APB direction
  input wire logic [frsr_pkg::ADDR_W-1:0] i_paddr, // APB address
  input wire logic [frsr_pkg::DATA_W-1:0] i_pwdata, // APB write data
  output logic [frsr_pkg::DATA_W-1:0] o_prdata, // APB read data
  output logic o_pready, // APB ready
  output logic o_pslverr, // APB error
  input wire logic i_lead_pulse, // Lead sensor pulse
  input wire logic i_fol_pulse, // Follower feedback pulse
  input wire logic i_sp_sel, // High selects setpoint two
  output logic o_sp_two, // Setpoint two active
  output logic [frsr_pkg::SPD_W-1:0] o_drive // Motor drive level
);
  import frsr_pkg::*;

  localparam longint RPM_K_L =
    longint'(SEC_PER_MIN) * longint'(CLK_KHZ) * 1000 / GATE_CYCLES;
  // Short gates give a large factor, so it is kept a full word wide
  localparam logic [31:0] RPM_K = 32'(RPM_K_L);
  localparam logic [31:0] GATE_LAST = 32'(GATE_CYCLES - 1);

  generate
    if (GATE_CYCLES < GATE_MIN || RPM_K_L < 1
        || RPM_K_L > 64'h00000000FFFFFFFF)
    begin : g_bad_gate
      $error("frsr_follower_ref: GATE_CYCLES out of range");
    end
  endgenerate

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a[1:0] == 2'b00) && (a <= OFF_STATUS);
  endfunction

  function automatic logic [15:0] sat16(input logic [NUM_W-1:0] q);
    sat16 = (|q[NUM_W-1:16]) ? SPD_SAT : q[15:0];
  endfunction

  // Gate divider and meters
  logic [31:0] gcnt_q, gcnt_d;
  logic gate_q, gate_d, start_q;
  logic [15:0] lead_cnt, fol_cnt;

  always_comb begin
    gate_d = (gcnt_q == GATE_LAST);
    gcnt_d = gate_d ? 32'h0 : gcnt_q + 32'h1;
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      gcnt_q <= 32'h0;
      gate_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      gcnt_q <= gcnt_d;
      gate_q <= gate_d;
      start_q <= gate_q;
    end
  end

  frsr_pulse_meter #(.CNT_W(SPD_W)) u_lead_meter (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_pulse(i_lead_pulse),
    .i_gate(gate_q),
    .o_count(lead_cnt)
  );

  frsr_pulse_meter #(.CNT_W(SPD_W)) u_fol_meter (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_pulse(i_fol_pulse),
    .i_gate(gate_q),
    .o_count(fol_cnt)
  );

  // Configuration registers and APB slave
  logic run_q, run_d;
  logic [15:0] lead_max_q, lead_max_d, fol_max_q, fol_max_d;
  logic [15:0] lead_ppr_q, lead_ppr_d, fol_ppr_q, fol_ppr_d;
  logic [15:0] fs_q, fs_d, sp1_q, sp1_d, sp2_q, sp2_d, ramp_q, ramp_d;
  logic [31:0] prdata_d;
  logic pready_d, pslverr_d, wr_en, sp_two_d;
  logic [15:0] lead_rpm_q, fol_rpm_q, target_q, ref_q, drive_q;

  always_comb begin
    run_d = run_q;
    lead_max_d = lead_max_q;
    fol_max_d = fol_max_q;
    lead_ppr_d = lead_ppr_q;
    fol_ppr_d = fol_ppr_q;
    fs_d = fs_q;
    sp1_d = sp1_q;
    sp2_d = sp2_q;
    ramp_d = ramp_q;
    sp_two_d = i_sp_sel;
    pready_d = i_psel & ~i_penable;
    pslverr_d = pready_d & ~is_mapped(i_paddr);
    prdata_d = 32'h0;
    if (pready_d && !i_pwrite) begin
      case (i_paddr)
        OFF_CTRL: prdata_d[CTRL_RUN_BIT] = run_q;
        OFF_LEAD_MAX: prdata_d[15:0] = lead_max_q;
        OFF_FOL_MAX: prdata_d[15:0] = fol_max_q;
        OFF_LEAD_PPR: prdata_d[15:0] = lead_ppr_q;
        OFF_FOL_PPR: prdata_d[15:0] = fol_ppr_q;
        OFF_FULL_SCALE: prdata_d[15:0] = fs_q;
        OFF_SP_ONE: prdata_d[15:0] = sp1_q;
        OFF_SP_TWO: prdata_d[15:0] = sp2_q;
        OFF_RAMP: prdata_d[15:0] = ramp_q;
        OFF_LEAD_SPD: prdata_d[15:0] = lead_rpm_q;
        OFF_FOL_SPD: prdata_d[15:0] = fol_rpm_q;
        OFF_TARGET: prdata_d[15:0] = target_q;
        OFF_REF: prdata_d[15:0] = ref_q;
        OFF_DRIVE: prdata_d[15:0] = drive_q;
        OFF_STATUS: prdata_d[STATUS_SP_BIT] = o_sp_two;
        default: prdata_d = 32'h0;
      endcase
    end
    // Write lands on the access edge that samples pready
    wr_en = i_psel & i_penable & o_pready & i_pwrite & ~o_pslverr;
    if (wr_en) begin
      case (i_paddr)
        OFF_CTRL: run_d = i_pwdata[CTRL_RUN_BIT];
        OFF_LEAD_MAX: lead_max_d = i_pwdata[15:0];
        OFF_FOL_MAX: fol_max_d = i_pwdata[15:0];
        OFF_LEAD_PPR: lead_ppr_d = i_pwdata[15:0];
        OFF_FOL_PPR: fol_ppr_d = i_pwdata[15:0];
        OFF_FULL_SCALE: fs_d = i_pwdata[15:0];
        OFF_SP_ONE: sp1_d = i_pwdata[15:0];
        OFF_SP_TWO: sp2_d = i_pwdata[15:0];
        OFF_RAMP: ramp_d = i_pwdata[15:0];
        default: run_d = run_q;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      run_q <= DEF_RUN;
      lead_max_q <= DEF_LEAD_MAX;
      fol_max_q <= DEF_FOL_MAX;
      lead_ppr_q <= DEF_PPR;
      fol_ppr_q <= DEF_PPR;
      fs_q <= DEF_FULL_SCALE;
      sp1_q <= DEF_SP;
      sp2_q <= DEF_SP;
      ramp_q <= DEF_RAMP;
      o_sp_two <= 1'b0;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0;
    end else begin
      run_q <= run_d;
      lead_max_q <= lead_max_d;
      fol_max_q <= fol_max_d;
      lead_ppr_q <= lead_ppr_d;
      fol_ppr_q <= fol_ppr_d;
      fs_q <= fs_d;
      sp1_q <= sp1_d;
      sp2_q <= sp2_d;
      ramp_q <= ramp_d;
      o_sp_two <= sp_two_d;
      o_pready <= pready_d;
      o_pslverr <= pslverr_d;
      o_prdata <= prdata_d;
    end
  end

  // Serial divider sequence: lead, follower, target, then loop update
  frsr_state_e state_q, state_d;
  logic [NUM_W-1:0] num_q, num_d, quot_q, quot_d, quot_nx;
  logic [DEN_W-1:0] den_q, den_d;
  logic [DEN_W:0] rem_q, rem_d, shifted;
  logic [5:0] bit_q, bit_d;
  logic [15:0] lead_rpm_d, fol_rpm_d, target_d, ref_d, drive_d, sp_act;
  logic signed [17:0] err, sum;
  logic take;

  always_comb begin
    sp_act = o_sp_two ? sp2_q : sp1_q;
    shifted = {rem_q[DEN_W-1:0], num_q[NUM_W-1]};
    take = shifted >= {1'b0, den_q};
    quot_nx = {quot_q[NUM_W-2:0], take};
    err = $signed({2'b00, ref_q}) - $signed({2'b00, fol_rpm_q});
    sum = $signed({2'b00, drive_q}) + (err >>> LOOP_SHIFT);
    state_d = state_q;
    num_d = num_q;
    den_d = den_q;
    rem_d = rem_q;
    quot_d = quot_q;
    bit_d = bit_q;
    lead_rpm_d = lead_rpm_q;
    fol_rpm_d = fol_rpm_q;
    target_d = target_q;
    ref_d = ref_q;
    drive_d = drive_q;
    case (state_q)
      S_IDLE: begin
        if (start_q) begin
          num_d = NUM_W'(lead_cnt) * NUM_W'(RPM_K);
          den_d = DEN_W'(lead_ppr_q);
          rem_d = '0;
          quot_d = '0;
          bit_d = DIV_LAST;
          state_d = S_LEAD;
        end
      end
      S_LEAD, S_FOL, S_TGT: begin
        num_d = num_q << 1;
        rem_d = take ? shifted - {1'b0, den_q} : shifted;
        quot_d = quot_nx;
        bit_d = bit_q - 6'h01;
        if (bit_q == 6'h00) begin
          rem_d = '0;
          quot_d = '0;
          bit_d = DIV_LAST;
          if (state_q == S_LEAD) begin
            lead_rpm_d = sat16(quot_nx);
            num_d = NUM_W'(fol_cnt) * NUM_W'(RPM_K);
            den_d = DEN_W'(fol_ppr_q);
            state_d = S_FOL;
          end else if (state_q == S_FOL) begin
            fol_rpm_d = sat16(quot_nx);
            // Lead times follower max times setpoint over lead max times FS
            num_d = NUM_W'(lead_rpm_q) * NUM_W'(fol_max_q)
                    * NUM_W'(sp_act);
            den_d = DEN_W'(lead_max_q) * DEN_W'(fs_q);
            state_d = S_TGT;
          end else begin
            // Zero divisor yields all ones, so it saturates
            target_d = run_q ? sat16(quot_nx) : 16'h0000;
            state_d = S_LOOP;
          end
        end
      end
      S_LOOP: begin
        // Slew toward target by at most the ramp step per gate
        if (target_q > ref_q) begin
          ref_d = (target_q - ref_q > ramp_q) ? ref_q + ramp_q
                                               : target_q;
        end else begin
          ref_d = (ref_q - target_q > ramp_q) ? ref_q - ramp_q
                                               : target_q;
        end
        // Integral action on speed error, clamped to drive range
        if (!run_q || sum < 0) begin
          drive_d = 16'h0000;
        end else if (sum > $signed({2'b00, SPD_SAT})) begin
          drive_d = SPD_SAT;
        end else begin
          drive_d = sum[15:0];
        end
        state_d = S_IDLE;
      end
      default: state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= S_IDLE;
      num_q <= '0;
      den_q <= '0;
      rem_q <= '0;
      quot_q <= '0;
      bit_q <= 6'h00;
      lead_rpm_q <= 16'h0000;
      fol_rpm_q <= 16'h0000;
      target_q <= 16'h0000;
      ref_q <= 16'h0000;
      drive_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      num_q <= num_d;
      den_q <= den_d;
      rem_q <= rem_d;
      quot_q <= quot_d;
      bit_q <= bit_d;
      lead_rpm_q <= lead_rpm_d;
      fol_rpm_q <= fol_rpm_d;
      target_q <= target_d;
      ref_q <= ref_d;
      drive_q <= drive_d;
    end
  end

  assign o_drive = drive_q;

  // Checks
  logic boot_q;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      boot_q <= 1'b1;
    end else begin
      boot_q <= 1'b0;
    end
  end

  reset_defaults_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    boot_q |-> lead_max_q == 16'd2000 && fol_max_q == 16'd2000
      && lead_ppr_q == 16'd60 && fol_ppr_q == 16'd60 && fs_q == 16'd1000)
    else $error("scaling defaults wrong after reset");

  setpoint_zero_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    boot_q |-> sp1_q == 16'h0000 && sp2_q == 16'h0000)
    else $error("setpoints not zero after reset");

  setpoint_pick_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (state_q == S_TGT && $past(state_q) == S_FOL)
      |-> num_q == 48'(lead_rpm_q) * 48'(fol_max_q)
        * 48'($past(i_sp_sel, 2) ? sp2_q : sp1_q))
    else $error("target numerator used wrong setpoint");

  lead_speed_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (state_q == S_FOL && $past(state_q) == S_LEAD && lead_ppr_q != 0
      && lead_rpm_q != SPD_SAT)
      |-> 48'(lead_rpm_q) * lead_ppr_q <= 48'(lead_cnt) * RPM_K
        && 48'(lead_cnt) * RPM_K < (48'(lead_rpm_q) + 1) * lead_ppr_q)
    else $error("lead speed conversion wrong");

  fol_speed_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (state_q == S_TGT && $past(state_q) == S_FOL && fol_ppr_q != 0
      && fol_rpm_q != SPD_SAT)
      |-> 48'(fol_rpm_q) * fol_ppr_q <= 48'(fol_cnt) * RPM_K
        && 48'(fol_cnt) * RPM_K < (48'(fol_rpm_q) + 1) * fol_ppr_q)
    else $error("follower speed conversion wrong");

  full_scale_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (state_q == S_LOOP && run_q && den_q != 0
      && $past(sp_act, 49) == fs_q && lead_rpm_q == lead_max_q)
      |-> target_q == fol_max_q)
    else $error("full scale does not give follower maximum");

  target_ratio_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (state_q == S_LOOP && run_q && target_q != SPD_SAT)
      |-> 64'(target_q) * den_q <= 64'($past(num_q, 48))
        && 64'($past(num_q, 48)) < (64'(target_q) + 1) * den_q)
    else $error("target not the scaled ratio");

  ramp_limit_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (ref_q != $past(ref_q)) |-> $past(state_q) == S_LOOP
      && (ref_q > $past(ref_q) ? ref_q - $past(ref_q)
                               : $past(ref_q) - ref_q) <= $past(ramp_q))
    else $error("reference step exceeds ramp");

  drive_track_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (state_q == S_LOOP && run_q && drive_q != SPD_SAT
      && {1'b0, ref_q} >= {1'b0, fol_rpm_q} + LOOP_ERR_MIN)
      |=> drive_q > $past(drive_q))
    else $error("drive not raised on slow follower");

  gate_refresh_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (lead_cnt != $past(lead_cnt) || fol_cnt != $past(fol_cnt))
      |-> $past(gate_q))
    else $error("pulse count changed outside gate");
endmodule

// ---- design/frsr_pkg.sv ----
// Purpose: Constants for the follower ratio speed reference block
// Assumes: 100 MHz system clock, APB register access, 32-bit data
// Notes: Speeds in RPM, ratio values in thousandths (1000 = 1.000)
package frsr_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SPD_W = 16;
  localparam int NUM_W = 48;
  localparam int DEN_W = 32;
  localparam logic [5:0] DIV_LAST = 6'h2F;

  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_LEAD_MAX = 8'h04;
  localparam logic [7:0] OFF_FOL_MAX = 8'h08;
  localparam logic [7:0] OFF_LEAD_PPR = 8'h0C;
  localparam logic [7:0] OFF_FOL_PPR = 8'h10;
  localparam logic [7:0] OFF_FULL_SCALE = 8'h14;
  localparam logic [7:0] OFF_SP_ONE = 8'h18;
  localparam logic [7:0] OFF_SP_TWO = 8'h1C;
  localparam logic [7:0] OFF_RAMP = 8'h20;
  localparam logic [7:0] OFF_LEAD_SPD = 8'h24;
  localparam logic [7:0] OFF_FOL_SPD = 8'h28;
  localparam logic [7:0] OFF_TARGET = 8'h2C;
  localparam logic [7:0] OFF_REF = 8'h30;
  localparam logic [7:0] OFF_DRIVE = 8'h34;
  localparam logic [7:0] OFF_STATUS = 8'h38;

  localparam int CTRL_RUN_BIT = 0;
  localparam int STATUS_SP_BIT = 0;

  localparam logic [15:0] DEF_LEAD_MAX = 16'h07D0;
  localparam logic [15:0] DEF_FOL_MAX = 16'h07D0;
  localparam logic [15:0] DEF_PPR = 16'h003C;
  localparam logic [15:0] DEF_FULL_SCALE = 16'h03E8;
  localparam logic [15:0] DEF_SP = 16'h0000;
  localparam logic [15:0] DEF_RAMP = 16'h0064;
  localparam logic DEF_RUN = 1'b0;
  localparam logic [15:0] SPD_SAT = 16'hFFFF;

  localparam int CLK_KHZ = 100_000;
  localparam int GATE_MS = 100;
  localparam int GATE_CYCLES_DEF = GATE_MS * CLK_KHZ;
  localparam int GATE_MIN = 256;
  localparam int SEC_PER_MIN = 60;
  localparam int LOOP_SHIFT = 4;
  localparam logic [16:0] LOOP_ERR_MIN = 17'h00010;

  typedef enum logic [2:0] {
    S_IDLE, S_LEAD, S_FOL, S_TGT, S_LOOP
  } frsr_state_e;
endpackage

// ---- design/frsr_pulse_meter.sv ----
// Purpose: Counts rising edges of a sensor pulse over one gate period
// Assumes: Pulse input synchronous to i_clk, gate is a one-cycle pulse
// Notes: Count saturates instead of wrapping
`timescale 1ns/1ps
module frsr_pulse_meter #(
  parameter int CNT_W = 16
) (
  input wire logic i_clk, // System clock
  input wire logic i_rst_b, // Async reset, active low
  input wire logic i_pulse, // Sensor pulse level
  input wire logic i_gate, // End of gate period
  output logic [CNT_W-1:0] o_count // Edges in last gate
);
  logic prev_q, prev_d;
  logic [CNT_W-1:0] run_q, run_d, cnt_q, cnt_d;
  logic rise;

  generate
    if (CNT_W < 2) begin : g_bad_w
      $error("frsr_pulse_meter: CNT_W too small");
    end
  endgenerate

  always_comb begin
    rise = i_pulse & ~prev_q;
    prev_d = i_pulse;
    cnt_d = cnt_q;
    run_d = run_q;
    if (i_gate) begin
      cnt_d = run_q;
      run_d = {{(CNT_W-1){1'b0}}, rise};
    end else if (rise && run_q != {CNT_W{1'b1}}) begin
      run_d = run_q + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prev_q <= 1'b0;
      run_q <= '0;
      cnt_q <= '0;
    end else begin
      prev_q <= prev_d;
      run_q <= run_d;
      cnt_q <= cnt_d;
    end
  end

  assign o_count = cnt_q;
endmodule

// ---- test/frsr_sensor_model.sv ----
// Purpose: Lead pulse sensor and follower feedback sensor stand-ins
// Assumes: Periods in clock cycles, zero period means a stopped shaft
// Notes: A period that divides the gate gives an exact edge count
`timescale 1ns/1ps
module frsr_sensor_model (
  input wire logic i_clk, // System clock
  input wire logic i_rst_b, // Async reset, active low
  input wire logic [15:0] i_lead_period, // Lead pulse period
  input wire logic [15:0] i_fol_period, // Follower pulse period
  output logic o_lead_pulse, // Lead sensor pulse
  output logic o_fol_pulse // Follower sensor pulse
);
  logic [15:0] lead_cnt;
  logic [15:0] fol_cnt;

  // Shrinking the period below the current count restarts the count at once
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lead_cnt <= 16'h0000;
      fol_cnt <= 16'h0000;
    end else begin
      lead_cnt <= (lead_cnt + 16'h1 >= i_lead_period) ? 16'h0
                  : lead_cnt + 16'h1;
      fol_cnt <= (fol_cnt + 16'h1 >= i_fol_period) ? 16'h0
                 : fol_cnt + 16'h1;
    end
  end

  assign o_lead_pulse = (i_lead_period != 0) && (lead_cnt < i_lead_period / 2);
  assign o_fol_pulse = (i_fol_period != 0) && (fol_cnt < i_fol_period / 2);
endmodule

// ---- test/tb_top.sv ----
// Purpose: Self-checking bench for the follower speed reference block
// Assumes: Short gate of 1000 cycles, reads checked from a queue
// Notes: Settle waits align to mid-gate so updates land between reads, not during them
`timescale 1ns/1ps
module tb_top;
  import frsr_pkg::*;
  localparam int GC = 1000;
  localparam longint KR = longint'(60) * 100_000_000 / GC;
  localparam int LIMIT = 90000;
  logic i_clk, i_rst_b, psel, penable, pwrite, sp_sel;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, o_prdata;
  logic o_pready, o_pslverr, lead_p, fol_p, o_sp_two;
  logic [SPD_W-1:0] o_drive, d1, d2;
  logic [15:0] lead_per, fol_per;
  logic [32:0] exp_q[$];
  logic [7:0] ra[7];
  int rv[7];
  int err_count, n_checks, cyc, r;

  frsr_follower_ref #(.GATE_CYCLES(GC)) i_dut (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_lead_pulse(lead_p), .i_fol_pulse(fol_p), .i_sp_sel(sp_sel),
    .o_sp_two(o_sp_two), .o_drive(o_drive));

  frsr_sensor_model i_sens (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_lead_period(lead_per),
    .i_fol_period(fol_per), .o_lead_pulse(lead_p), .o_fol_pulse(fol_p));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic summarize();
    $display("Checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) cyc <= 0;
    else cyc <= cyc + 1;
  end

  always @(posedge i_clk) begin
    if (cyc == LIMIT) begin
      err_count++;
      summarize();
    end
  end

  // Compare each read answer with the oldest note
  always @(posedge i_clk) begin
    if (psel && penable && !pwrite && o_pready === 1'b1) begin
      if (exp_q.size() > 0) chk({o_pslverr, o_prdata}, exp_q.pop_front());
      else chk({o_pslverr, o_prdata}, 33'h1FFFFFFFF);
    end
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    if (n >= 20) chk(33'h0, 33'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic er);
    exp_q.push_back({er, e});
    apb(1'b0, a, 32'h0);
  endtask

  // Mid-gate alignment keeps reads clear of the update window
  task automatic settle(input int n);
    repeat (n) begin
      @(posedge i_clk);
      while (cyc % GC != 500) @(posedge i_clk);
    end
  endtask

  task automatic endtest(input string s);
    $display("Test %s finished, mismatches so far %0d", s, err_count);
  endtask

  function automatic logic [31:0] rpm(input longint cnt, input longint ppr);
    longint q;
    q = cnt * KR / ppr;
    return (q > 65535) ? 32'h0000FFFF : 32'(q);
  endfunction

  function automatic logic [31:0] tgt(input longint l, input longint s,
                                      input longint fs);
    longint q;
    q = l * 2000 * s / (2000 * fs);
    return (q > 65535) ? 32'h0000FFFF : 32'(q);
  endfunction

  initial begin
    i_rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sp_sel = 1'b0;
    lead_per = 16'd50;
    fol_per = 16'd40;
    err_count = 0;
    n_checks = 0;
    r = $urandom(48554);
    ra = '{OFF_LEAD_MAX, OFF_FOL_MAX, OFF_LEAD_PPR, OFF_FOL_PPR,
           OFF_FULL_SCALE, OFF_SP_ONE, OFF_SP_TWO};
    rv = '{2000, 2000, 60, 60, 1000, 0, 0};
    repeat (8) @(posedge i_clk);
    i_rst_b <= 1'b1;
    for (int i = 0; i < 7; i++) rd(ra[i], rv[i], 1'b0);
    rd(8'h3C, 32'h0, 1'b1);
    rd(8'h05, 32'h0, 1'b1);
    wr(OFF_FULL_SCALE, 32'hABCD03E8);
    rd(OFF_FULL_SCALE, 32'h3E8, 1'b0);
    endtest("defaults");

    settle(2);
    rd(OFF_LEAD_SPD, rpm(20, 60), 1'b0);
    rd(OFF_FOL_SPD, rpm(25, 60), 1'b0);
    // Large pulses-per-revolution settings keep a short gate's speed below saturation
    wr(OFF_LEAD_PPR, 32'd30000);
    wr(OFF_FOL_PPR, 32'd50000);
    lead_per <= 16'd100;
    rd(OFF_LEAD_SPD, rpm(20, 60), 1'b0);
    settle(2);
    rd(OFF_LEAD_SPD, rpm(10, 30000), 1'b0);
    rd(OFF_FOL_SPD, rpm(25, 50000), 1'b0);
    wr(OFF_LEAD_PPR, 32'd60000);
    wr(OFF_FOL_PPR, 32'd60000);
    lead_per <= 16'd50;
    fol_per <= 16'd0;
    settle(2);
    rd(OFF_FOL_SPD, 32'h0, 1'b0);
    endtest("speeds");

    wr(OFF_CTRL, 32'h1);
    wr(OFF_SP_ONE, 32'd1000);
    for (int k = 1; k <= 3; k++) begin
      settle(1);
      rd(OFF_REF, 32'(100 * k), 1'b0);
    end
    wr(OFF_RAMP, 32'h0);
    settle(1);
    d1 = o_drive;
    settle(1);
    d2 = o_drive;
    chk(33'(d2 - d1), 33'd18);
    rd(OFF_REF, 32'd300, 1'b0);
    rd(OFF_DRIVE, 32'd54, 1'b0);
    endtest("ramp and drive");

    r = $urandom_range(1000);
    rd(OFF_TARGET, tgt(2000, 1000, 1000), 1'b0);
    wr(OFF_SP_TWO, r);
    sp_sel <= 1'b1;
    repeat (2) @(posedge i_clk);
    chk(o_sp_two, 1'b1);
    rd(OFF_STATUS, 32'h1, 1'b0);
    settle(1);
    rd(OFF_TARGET, tgt(2000, r, 1000), 1'b0);
    sp_sel <= 1'b0;
    lead_per <= 16'd100;
    settle(2);
    rd(OFF_TARGET, tgt(1000, 1000, 1000), 1'b0);
    wr(OFF_SP_ONE, 32'hABCDFFFF);
    wr(OFF_FULL_SCALE, 32'h1);
    settle(1);
    rd(OFF_SP_ONE, 32'hFFFF, 1'b0);
    rd(OFF_TARGET, tgt(1000, 65535, 1), 1'b0);
    wr(OFF_CTRL, 32'h0);
    settle(1);
    chk(o_drive, 16'h0000);
    rd(OFF_TARGET, 32'h0, 1'b0);
    endtest("ratio");
    summarize();
  end
endmodule
